// [src/csss_defines.svh]
// Offsets, field positions, reset values and timing counts of the clock block
`ifndef CSSS_DEFINES_SVH
`define CSSS_DEFINES_SVH
// Register byte addresses
`define CSS_ADDR_CTRL     8'h00
`define CSS_ADDR_TRIM     8'h04
`define CSS_ADDR_STAT     8'h08
// Control field positions
`define CSS_CTRL_STOP     0
`define CSS_CTRL_PDOWN    1
// Source select codes
`define CSS_SEL_RC128     4'h3
`define CSS_SEL_RC        4'h2
`define CSS_SEL_EXT       4'h0
// Factory defaults, stored sense (zero is programmed)
`define CSS_DEF_SEL       4'h2
`define CSS_DEF_STF       2'h2
`define CSS_DEF_DIV8      1'b0
`define CSS_DEF_TRIM      8'h80
// Start-up counts in cycles of the chosen oscillator
`define CSS_BASE_CK       16'h000E
`define CSS_LF_FAST_CK    16'h0400
`define CSS_LF_SLOW_CK    32768
`define CSS_OTHER_START_CK 6
// Time-out figures and watchdog oscillator rate
`define CSS_TOUT_SHORT_US 4100
`define CSS_TOUT_LONG_US  65000
`define CSS_WDT_KHZ       128
`define CSS_TOUT_SHORT_CYC ((`CSS_TOUT_SHORT_US * `CSS_WDT_KHZ + 999) / 1000)
`define CSS_TOUT_LONG_CYC  ((`CSS_TOUT_LONG_US * `CSS_WDT_KHZ + 999) / 1000)
// Bus responses
`define CSS_RESP_OKAY     2'h0
`define CSS_RESP_SLVERR   2'h2
`endif

// [src/csss_pkg.sv]
// Types shared by the clock block
`default_nettype none
package csss_pkg;
    // Start-up sequencer states, one-hot
    typedef enum logic [3:0] {
        ST_TOUT  = 4'b0001,
        ST_OSC   = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_PDOWN = 4'b1000
    } csss_state_e;
    // Start-up counter word
    typedef logic [15:0] csss_cnt_t;
endpackage
`default_nettype wire

// [src/csss_top.sv]
// Clock source selection, reset time-out and start-up gating with AXI4-Lite registers
//
// Implementation choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "csss_defines.svh"
// Function
// - Converter clock has its own gated output
// - Core clocks stop while converter clock runs
// - Codes select the three crystal options
// - Codes select RC128, calibrated RC, external
// - Fuse bit one means unprogrammed
// - Default: RC source, max start-up, divide
// - Internal reset held for time-out after release
// - Time-out counted in watchdog cycles, fuse-chosen
// - Low-frequency option uses watch crystal oscillator
// - Low-frequency start-up counts from select bits
// - Calibration byte loaded into trim during source reset; block reset loads 80h
// - Software trim writes retune RC oscillator
// - Watchdog oscillator always times the time-out
// - Divide-by-eight fuse divides system clock
module csss_top
    import csss_pkg::*;
#(
    parameter int unsigned TOUT_SHORT_CYC = `CSS_TOUT_SHORT_CYC,
    parameter int unsigned TOUT_LONG_CYC  = `CSS_TOUT_LONG_CYC,
    parameter int unsigned LF_SLOW_CK     = `CSS_LF_SLOW_CK,
    parameter int unsigned OTHER_START_CK = `CSS_OTHER_START_CK
) (
    input  wire logic       core_clk_i,             // 100 MHz bus clock
    input  wire logic       reset_n_i,              // Asynchronous reset
    input  wire logic       reset_src_n_i,          // Other reset sources, low active
    input  wire logic [3:0] source_select_fuses_i,  // Stored fuse values
    input  wire logic [1:0] startup_time_fuses_i,
    input  wire logic       divide_by_eight_fuse_i,
    input  wire logic [7:0] calib_byte_i,           // Stored calibration byte
    input  wire logic       wdt_tick_i,             // Watchdog oscillator cycle
    input  wire logic       lp_xtal_tick_i,         // Low-power crystal cycle
    input  wire logic       fs_xtal_tick_i,         // Full-swing crystal cycle
    input  wire logic       lf_xtal_tick_i,         // Watch crystal cycle
    input  wire logic       rc128_tick_i,           // 128 kHz RC cycle
    input  wire logic       rc_tick_i,              // Calibrated RC cycle
    input  wire logic       ext_clk_tick_i,         // External clock cycle
    input  wire logic       wake_i,                 // Wake-up event
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic [1:0]      s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [7:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic [31:0]     s_axi_rdata,
    output logic [1:0]      s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    output logic            cpu_io_clk_o,           // Core and peripheral clock tick
    output logic            converter_clock_o,      // Converter clock tick
    output logic            int_reset_n_o,          // Internal reset, low active
    output logic [7:0]      oscillator_trim_o       // RC trim value
);

    // Counter widths limit the parameters
    if (TOUT_LONG_CYC > 65535 || TOUT_SHORT_CYC > 65535 || LF_SLOW_CK > 65521 || OTHER_START_CK > 65521 ||
        OTHER_START_CK == 0) begin : g_chk
        $error("csss_top: count parameter out of range");
    end

    csss_state_e st_r, st_nxt;             // Sequencer state
    csss_cnt_t   cnt_r, cnt_nxt;           // Time-out and start-up counter
    logic        boot_r, boot_nxt;         // Start-up follows a reset
    logic [3:0]  sel_r, sel_nxt;           // Latched source select
    logic [1:0]  stf_r, stf_nxt;           // Latched start-up field
    logic        div8_r, div8_nxt;         // Latched divide fuse, stored sense
    logic [2:0]  div_r, div_nxt;           // Divide-by-eight phase
    logic        cpu_r, cpu_nxt;
    logic        conv_r, conv_nxt;
    logic        irst_r, irst_nxt;
    logic [1:0]  ctrl_r, ctrl_nxt;         // Stop and power-down requests
    logic [7:0]  trim_r, trim_nxt;
    logic        bvalid_r, bvalid_nxt;
    logic [1:0]  bresp_r, bresp_nxt;
    logic        rvalid_r, rvalid_nxt;
    logic [1:0]  rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        src_tick;                 // Cycle of the chosen oscillator
    logic        sys_tick;                 // Divided system clock cycle
    csss_cnt_t   tout_lim;                 // Watchdog cycles of time-out
    csss_cnt_t   start_lim;                // Oscillator cycles of start-up
    logic        wr_go, rd_go;

    // Oscillator selection from the latched fuse code
    always_comb begin
        if (sel_r[3]) begin
            src_tick = lp_xtal_tick_i;
        end else if (sel_r[3:1] == 3'h3) begin
            src_tick = fs_xtal_tick_i;
        end else if (sel_r[3:1] == 3'h2) begin
            src_tick = lf_xtal_tick_i;
        end else if (sel_r == `CSS_SEL_RC128) begin
            src_tick = rc128_tick_i;
        end else if (sel_r == `CSS_SEL_EXT) begin
            src_tick = ext_clk_tick_i;
        end else begin
            src_tick = rc_tick_i;                       // reserved code too
        end
    end

    // Time-out and start-up lengths from the fuses
    always_comb begin
        case (stf_r)
            2'h0:    tout_lim = 16'h0000;
            2'h1:    tout_lim = 16'(TOUT_SHORT_CYC);
            default: tout_lim = 16'(TOUT_LONG_CYC);
        endcase
        if (sel_r[3:1] == 3'h2) begin
            start_lim = sel_r[0] ? 16'(LF_SLOW_CK) : `CSS_LF_FAST_CK;
        end else begin
            start_lim = 16'(OTHER_START_CK);
        end
        if (boot_r) begin
            start_lim = start_lim + `CSS_BASE_CK;
        end
    end

    // Divider and gated clock outputs
    always_comb begin
        sys_tick = src_tick && (div8_r || div_r == 3'h7);
        div_nxt  = div_r;
        if (st_r == ST_RUN && src_tick) begin
            div_nxt = div_r + 3'h1;
        end
        cpu_nxt  = sys_tick && st_r == ST_RUN && !ctrl_r[`CSS_CTRL_STOP];
        conv_nxt = sys_tick && st_r == ST_RUN;
    end

    // Sequencer next state
    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        boot_nxt = boot_r;
        sel_nxt  = sel_r;
        stf_nxt  = stf_r;
        div8_nxt = div8_r;
        case (st_r)
            ST_TOUT: begin
                if (cnt_r >= tout_lim) begin
                    st_nxt  = ST_OSC;
                    cnt_nxt = 16'h0000;
                end else if (wdt_tick_i) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            ST_OSC: begin
                if (cnt_r >= start_lim) begin
                    st_nxt   = ST_RUN;
                    boot_nxt = 1'b0;
                end else if (src_tick) begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            ST_RUN: begin
                if (ctrl_r[`CSS_CTRL_PDOWN]) begin
                    st_nxt = ST_PDOWN;
                end
            end
            ST_PDOWN: begin
                if (!ctrl_r[`CSS_CTRL_PDOWN]) begin
                    st_nxt  = ST_OSC;
                    cnt_nxt = 16'h0000;
                end
            end
            default: begin
                st_nxt = ST_TOUT;
            end
        endcase
        if (!reset_src_n_i) begin
            st_nxt   = ST_TOUT;
            cnt_nxt  = 16'h0000;
            boot_nxt = 1'b1;
            sel_nxt  = source_select_fuses_i;
            stf_nxt  = startup_time_fuses_i;
            div8_nxt = divide_by_eight_fuse_i;
        end
        irst_nxt = !(st_nxt == ST_TOUT || (st_nxt == ST_OSC && boot_nxt));
    end

    // Bus handshakes
    assign wr_go          = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign rd_go          = s_axi_arvalid && !rvalid_r;
    assign s_axi_awready  = wr_go;
    assign s_axi_wready   = wr_go;
    assign s_axi_arready  = rd_go;
    assign s_axi_bvalid   = bvalid_r;
    assign s_axi_bresp    = bresp_r;
    assign s_axi_rvalid   = rvalid_r;
    assign s_axi_rresp    = rresp_r;
    assign s_axi_rdata    = rdata_r;

    // Register writes, reads and hardware updates
    always_comb begin
        ctrl_nxt   = ctrl_r;
        trim_nxt   = trim_r;
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt  = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt  = rresp_r;
        rdata_nxt  = rdata_r;
        if (wr_go) begin
            bvalid_nxt = 1'b1;
            bresp_nxt  = `CSS_RESP_OKAY;
            case (s_axi_awaddr)
                `CSS_ADDR_CTRL: if (s_axi_wstrb[0]) ctrl_nxt = s_axi_wdata[1:0];
                `CSS_ADDR_TRIM: if (s_axi_wstrb[0]) trim_nxt = s_axi_wdata[7:0];
                `CSS_ADDR_STAT: bresp_nxt = `CSS_RESP_OKAY;
                default:        bresp_nxt = `CSS_RESP_SLVERR;
            endcase
        end
        if (rd_go) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = `CSS_RESP_OKAY;
            case (s_axi_araddr)
                `CSS_ADDR_CTRL: rdata_nxt = {30'h0, ctrl_r};
                `CSS_ADDR_TRIM: rdata_nxt = {24'h0, trim_r};
                `CSS_ADDR_STAT: rdata_nxt = {20'h0, st_r, irst_r, div8_r, stf_r, sel_r};
                default: begin
                    rdata_nxt = 32'h0;
                    rresp_nxt = `CSS_RESP_SLVERR;
                end
            endcase
        end
        if (st_r == ST_PDOWN && wake_i) begin
            ctrl_nxt[`CSS_CTRL_PDOWN] = 1'b0;           // Wake clears power-down
        end
        if (!reset_src_n_i) begin
            ctrl_nxt = 2'h0;
            trim_nxt = calib_byte_i;
        end
    end

    // State registers
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r     <= ST_TOUT;
            cnt_r    <= 16'h0000;
            boot_r   <= 1'b1;
            sel_r    <= `CSS_DEF_SEL;
            stf_r    <= `CSS_DEF_STF;
            div8_r   <= `CSS_DEF_DIV8;
            div_r    <= 3'h0;
            cpu_r    <= 1'b0;
            conv_r   <= 1'b0;
            irst_r   <= 1'b0;
            ctrl_r   <= 2'h0;
            trim_r   <= `CSS_DEF_TRIM;
            bvalid_r <= 1'b0;
            bresp_r  <= 2'h0;
            rvalid_r <= 1'b0;
            rresp_r  <= 2'h0;
            rdata_r  <= 32'h0;
        end else begin
            st_r     <= st_nxt;
            cnt_r    <= cnt_nxt;
            boot_r   <= boot_nxt;
            sel_r    <= sel_nxt;
            stf_r    <= stf_nxt;
            div8_r   <= div8_nxt;
            div_r    <= div_nxt;
            cpu_r    <= cpu_nxt;
            conv_r   <= conv_nxt;
            irst_r   <= irst_nxt;
            ctrl_r   <= ctrl_nxt;
            trim_r   <= trim_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r  <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r  <= rresp_nxt;
            rdata_r  <= rdata_nxt;
        end
    end

    assign cpu_io_clk_o      = cpu_r;
    assign converter_clock_o = conv_r;
    assign int_reset_n_o     = irst_r;
    assign oscillator_trim_o = trim_r;

    // Checks on the sequencer and clock gating
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_src_reset;
        !reset_src_n_i;
    endsequence
    sequence s_tout_wait;
        st_r == ST_TOUT && reset_src_n_i && cnt_r < tout_lim;
    endsequence

    property p_restart;
        s_src_reset |=> st_r == ST_TOUT && cnt_r == 16'h0000 && !int_reset_n_o;
    endproperty
    a_restart: assert property (p_restart) else $error("reset source did not restart time-out");
    property p_hold;
        s_tout_wait |=> st_r == ST_TOUT ##0 !int_reset_n_o;
    endproperty
    a_hold: assert property (p_hold) else $error("internal reset released early");
    property p_wdt_count;
        s_tout_wait ##0 !wdt_tick_i |=> $stable(cnt_r);
    endproperty
    a_wdt_count: assert property (p_wdt_count) else $error("time-out advanced without watchdog cycle");
    property p_tout_len;
        $rose(st_r == ST_OSC) && boot_r |-> $past(cnt_r) >= $past(tout_lim);
    endproperty
    a_tout_len: assert property (p_tout_len) else $error("time-out shorter than selected");
    property p_trim_load;
        s_src_reset |=> trim_r == $past(calib_byte_i);
    endproperty
    a_trim_load: assert property (p_trim_load) else $error("calibration byte not loaded");
    property p_gate;
        st_r != ST_RUN |=> !cpu_io_clk_o && !converter_clock_o;
    endproperty
    a_gate: assert property (p_gate) else $error("clock passed before start-up done");
    property p_start_len;
        $rose(st_r == ST_RUN) |-> $past(cnt_r) >= $past(start_lim);
    endproperty
    a_start_len: assert property (p_start_len) else $error("start-up count cut short");
    property p_div8;
        st_r == ST_RUN && src_tick && !div8_r && div_r != 3'h7 |=> !converter_clock_o;
    endproperty
    a_div8: assert property (p_div8) else $error("divided clock ticked off phase");
    property p_stop;
        st_r == ST_RUN && sys_tick && ctrl_r[`CSS_CTRL_STOP] |=> converter_clock_o && !cpu_io_clk_o;
    endproperty
    a_stop: assert property (p_stop) else $error("converter clock not independent of core stop");

endmodule
`default_nettype wire

// [bench/csss_top_bench.sv]
// Self-checking bench of the clock source select and start-up block
`timescale 1ns/1ns
`default_nettype none
`include "csss_defines.svh"
module csss_top_bench
    import csss_pkg::*;
;
    localparam int TS = 4;   // Short time-out count
    localparam int TL = 8;   // Long time-out count
    localparam int LS = 16;  // Slow watch crystal start-up
    localparam int OS = 3;   // Start-up of the other sources
    logic        clk     = 1'b0;   // Bus clock
    logic        rst_n   = 1'b0;   // Block reset
    logic        rsrc_n  = 1'b1;   // Other reset sources
    logic [3:0]  sel     = 4'hF;   // Source select fuse inputs
    logic [1:0]  stf     = 2'h3;   // Start-up fuse inputs
    logic        div8    = 1'b1;   // Divide fuse input
    logic [7:0]  calib   = 8'h00;  // Calibration byte
    logic        wdt     = 1'b0;   // Watchdog tick
    logic [5:0]  tk      = 6'h00;  // Ticks: lp, fs, lf, rc128, rc, ext
    logic        wake    = 1'b0;   // Wake-up level
    logic [7:0]  awaddr  = 8'h00;  // Bus master side
    logic [7:0]  araddr  = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    wire logic   awready, wready, bvalid, arready, rvalid, cpu_clk, conv_clk, irst_n;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  trim;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;     // Cycle counter for the hang limit
    int n_cpu = 0;   // Core clock pulses seen
    int n_conv = 0;  // Converter clock pulses seen

    // Small counts keep the long start-up figures short
    csss_top #(.TOUT_SHORT_CYC(TS), .TOUT_LONG_CYC(TL), .LF_SLOW_CK(LS), .OTHER_START_CK(OS)) uut (
        .core_clk_i(clk), .reset_n_i(rst_n), .reset_src_n_i(rsrc_n), .source_select_fuses_i(sel),
        .startup_time_fuses_i(stf), .divide_by_eight_fuse_i(div8), .calib_byte_i(calib), .wdt_tick_i(wdt),
        .lp_xtal_tick_i(tk[0]), .fs_xtal_tick_i(tk[1]), .lf_xtal_tick_i(tk[2]), .rc128_tick_i(tk[3]),
        .rc_tick_i(tk[4]), .ext_clk_tick_i(tk[5]), .wake_i(wake), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_io_clk_o(cpu_clk), .converter_clock_o(conv_clk), .int_reset_n_o(irst_n), .oscillator_trim_o(trim));

    // Clock generator
    always #5 clk = ~clk;

    // Pulse counters and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cpu_clk === 1'b1) n_cpu <= n_cpu + 1;
        if (conv_clk === 1'b1) n_conv <= n_conv + 1;
        if (cyc == 60000) begin
            n_errors++;
            finish_test();
        end
    end

    // Expected figures
    function automatic int tout_of(input logic [1:0] u);
        return (u == 2'h0) ? 0 : ((u == 2'h1) ? TS : TL);
    endfunction
    function automatic int st_of(input logic [3:0] s);
        return (s[3:1] == 3'b010) ? (s[0] ? LS : 1024) : OS;
    endfunction
    function automatic int osc_of(input logic [3:0] s);
        if (s[3]) return 0;
        if (s[2:1] == 2'h3) return 1;
        if (s[2:1] == 2'h2) return 2;
        if (s == 4'h3) return 3;
        return (s == 4'h0) ? 5 : 4;
    endfunction

    // Compare tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("Error at %0t got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Register write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // Register read
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        bit done;
        done = 1'b0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                v = rdata;
                r = rresp;
                rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    // Oscillator ticks on the chosen source with noise on the others
    task automatic ticks(input int n, input int o);
        repeat (n) begin
            @(posedge clk);
            tk  <= 6'($urandom) | (6'h01 << o);
            wdt <= 1'b1;
            @(posedge clk);
            tk  <= 6'h00;
            wdt <= 1'b0;
        end
    endtask

    // One fuse setting: start-up, clocks, stop, power-down and wake
    task automatic run_case(input logic [3:0] s, input logic [1:0] u, input logic d, input logic [7:0] c,
                            input bit ab);
        int n;
        int e;
        int c0;
        int c1;
        logic [31:0] v;
        logic [1:0] r;
        e = tout_of(u) + st_of(s) + 14;
        @(posedge clk);
        rsrc_n <= 1'b0;
        sel    <= s;
        stf    <= u;
        div8   <= d;
        calib  <= c;
        repeat (3) @(posedge clk);
        rsrc_n <= 1'b1;
        chk(irst_n, 1'b0);
        // Interrupted start-up must begin again in full
        if (ab) begin
            ticks($urandom_range(e - 1, 1), osc_of(s));
            rsrc_n <= 1'b0;
            @(posedge clk);
            rsrc_n <= 1'b1;
        end
        n = 0;
        while (irst_n !== 1'b1 && n < e + 8) begin
            ticks(1, osc_of(s));
            n++;
        end
        chk_rng(n, e, e + 1);
        // Fuse inputs now move; latched values must stay
        sel <= 4'($urandom);
        stf <= 2'($urandom);
        rd(`CSS_ADDR_STAT, v, r);
        chk(v[11:0], {ST_RUN, 1'b1, d, u, s});
        chk(trim, c);
        c0 = n_cpu;
        c1 = n_conv;
        ticks(64, osc_of(s));
        repeat (3) @(posedge clk);
        chk(n_cpu - c0, d ? 64 : 8);
        chk(n_conv - c1, d ? 64 : 8);
        // Core clock stopped, converter clock running
        wr(`CSS_ADDR_CTRL, 32'h1, r);
        c0 = n_cpu;
        c1 = n_conv;
        ticks(64, osc_of(s));
        repeat (3) @(posedge clk);
        chk(n_cpu - c0, 0);
        chk(n_conv - c1, d ? 64 : 8);
        // Power-down, then wake and count the start-up again
        wr(`CSS_ADDR_CTRL, 32'h2, r);
        repeat (2) @(posedge clk);
        rd(`CSS_ADDR_STAT, v, r);
        chk(v[11:8], ST_PDOWN);
        c1 = n_conv;
        ticks(8, osc_of(s));
        repeat (2) @(posedge clk);
        chk(n_conv - c1, 0);
        wake <= 1'b1;
        repeat (2) @(posedge clk);
        wake <= 1'b0;
        repeat (2) @(posedge clk);
        ticks(st_of(s) - 1, osc_of(s));
        rd(`CSS_ADDR_STAT, v, r);
        chk(v[11:8], ST_OSC);
        ticks(2, osc_of(s));
        repeat (2) @(posedge clk);
        rd(`CSS_ADDR_STAT, v, r);
        chk(v[11:8], ST_RUN);
    endtask

    // Main sequence
    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic [7:0] t8;
        void'($urandom(32'h17E1C94C));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`CSS_ADDR_STAT, v, r);
        chk(v[7:0], 8'h22);
        chk(trim, 8'h80);
        // Every select code once, then random settings; code 4 takes the short watch crystal
        // start-up, acceptable as nothing here depends on a settled start-up frequency
        for (int i = 0; i < 20; i++) begin
            run_case((i < 16) ? 4'(i) : 4'($urandom), 2'($urandom), 1'($urandom), 8'($urandom), 1'($urandom));
        end
        // Software trim, read-only status, unmapped place
        t8 = 8'($urandom);
        wr(`CSS_ADDR_TRIM, {24'h0, t8}, r);
        chk(r, `CSS_RESP_OKAY);
        repeat (2) @(posedge clk);
        chk(trim, t8);
        rd(`CSS_ADDR_TRIM, v, r);
        chk(v[7:0], t8);
        wr(`CSS_ADDR_STAT, 32'h0, r);
        chk(r, `CSS_RESP_OKAY);
        rd(`CSS_ADDR_STAT, v, r);
        chk(v[11:7], {ST_RUN, 1'b1});
        rd(8'h0C, v, r);
        chk(r, `CSS_RESP_SLVERR);
        chk(v, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
